//--- hw/serial_channel_map.vh
/*
 * Register offsets, field positions, mode codes and timing constants
 * for the serial channel block.
 * Assumes inclusion by bare name from the design file.
 */
`ifndef SERIAL_CHANNEL_MAP_VH
`define SERIAL_CHANNEL_MAP_VH

// ==========================================================
// Register offsets (byte addresses, 12-bit address port)
// ==========================================================
`define ADDR_BUF_CH0        12'h200
`define ADDR_BUF_CH1        12'h208
`define ADDR_BUF_CH2        12'h210
`define ADDR_MODE_A         12'h201
`define ADDR_CTRL           12'h202
`define ADDR_BAUD_CTRL      12'h203
`define ADDR_FRAC_VAL       12'h204
`define ADDR_MODE_B         12'h205
`define ADDR_IRQ_CTRL       12'h206

// ==========================================================
// Field positions
// ==========================================================
`define MODE_SEL_LO         0
`define MODE_SEL_HI         1
`define MODE_A_RXE          5
`define MODE_B_FDPX         6
`define CTRL_CLK_LO         0
`define CTRL_CLK_HI         1
`define CTRL_EVEN           6
`define CTRL_PE             5
`define BAUD_N_LO           0
`define BAUD_N_HI           3
`define BAUD_ADDE           6
`define IRQ_TX_FLAG         3
`define IRQ_RX_FLAG         7

// ==========================================================
// Mode codes and values
// ==========================================================
`define MODE_SYNC_IO        2'h0
`define MODE_UART7          2'h1
`define CLKSEL_INT_OUT      2'h0
`define N_IS_16             4'h0
`define N_IS_1              4'h1
`define FRAC_ONE            4'hF
`define FRAC_SIXTEEN        5'h10
`define DATA_BITS_SYNC      4'h8
`define DATA_BITS_UART7     4'h7
`define UART_OVERSAMPLE     4'hF
`define UART_MID_SAMPLE     4'h7
`define BIT_CNT_ZERO        4'h0
`define DIV_ONE             5'h01
`define ZERO8               8'h00
`define ZERO4               4'h0
`define ZERO5               5'h00
`define RD_UNMAPPED         8'h00

`endif

//--- hw/serial_channel.v
/*
 * One serial channel: buffer register, synchronous I/O mode with
 * internal or external shift clock, and 7-bit asynchronous mode.
 * Assumes the register master on ref_clk, one-cycle strobes, and
 * that pin inputs arrive asynchronously.
 */
// Functional notes
// - Fractional divide only async, N 2..15
// - Buffer write hits transmit, read returns receive
// - Sync mode: internal or external shift clock
// - Internal clock: each write sends 8 bits
// - After last sync bit set transmit flag
// - External clock: shift 8 bits after write
// - Internal receive runs only with flag clear
// - After 8 bits copy byte, set flag
// - Receive enable starts first clock burst
// - External receive only after flag cleared
// - Control 00: drive clock, tx fall, rx rise
// - Full duplex bit runs tx and rx together
// - Mode field 00 selects sync I/O
// - Mode field 01 selects 7-bit async
// - Parity only when enabled, sense selectable
`timescale 1ns/1ps
`include "serial_channel_map.vh"

module serial_channel
(
    input  wire        ref_clk,          // System clock
    input  wire        sys_rst,          // Async reset, active high
    input  wire        presc_tick,       // Baud prescaler tick
    input  wire [11:0] reg_addr,         // Register address
    input  wire [7:0]  reg_wdata,        // Write data
    input  wire        reg_wr,           // Write strobe
    input  wire        reg_rd,           // Read strobe
    output reg  [7:0]  reg_rdata,        // Read data, one cycle later
    output reg         transmit_data_pin,// Serial data out
    input  wire        receive_data_pin, // Serial data in
    output reg         shift_clock_pin_o,  // Shift clock out
    output reg         shift_clock_pin_oe, // Shift clock drive enable
    input  wire        shift_clock_pin_i,  // Shift clock in
    output reg         transmit_interrupt, // Transmit request
    output reg         receive_interrupt   // Receive request
);

    // ==========================================================
    // Registers
    // ==========================================================
    reg [7:0] mode_a_ff;       // channel_mode_reg_a
    reg [7:0] mode_b_ff;       // channel_mode_reg_b
    reg [7:0] ctrl_ff;         // channel_control_reg
    reg [7:0] baud_ff;         // baud_control_reg
    reg [3:0] frac_ff;         // fractional_divide_value
    reg       tx_flag_ff;      // transmit_irq_flag
    reg       rx_flag_ff;      // receive_irq_flag
    reg [7:0] tx_buf_ff;       // Transmit buffer
    reg [7:0] rx_buf_ff;       // Receive buffer (second stage)
    reg       tx_pend_ff;      // Transmit buffer holds data
    reg [2:0] rxd_sync_ff;     // Data in synchroniser and history
    reg [2:0] sck_sync_ff;     // Shift clock synchroniser and history

    wire [1:0] mode_sel  = mode_a_ff[`MODE_SEL_HI:`MODE_SEL_LO];
    wire       rx_en     = mode_a_ff[`MODE_A_RXE];
    wire       is_sync   = (mode_sel == `MODE_SYNC_IO);
    wire       is_uart7  = (mode_sel == `MODE_UART7);
    wire       int_clk   = (ctrl_ff[`CTRL_CLK_HI:`CTRL_CLK_LO] == `CLKSEL_INT_OUT);
    wire       full_dpx  = mode_b_ff[`MODE_B_FDPX];
    wire [3:0] n_val     = baud_ff[`BAUD_N_HI:`BAUD_N_LO];
    wire       buf_hit   = (reg_addr == `ADDR_BUF_CH0);
    wire       buf_wr    = reg_wr & buf_hit;
    wire       buf_rd    = reg_rd & buf_hit;
    wire       rxd_s     = rxd_sync_ff[1];
    wire       sck_s     = sck_sync_ff[1];
    wire       sck_rise  = sck_s & ~sck_sync_ff[2];
    wire       sck_fall  = ~sck_s & sck_sync_ff[2];

    // ==========================================================
    // Baud divider: N, or N + (16-K)/16 in async with N 2..15
    // ==========================================================
    reg  [4:0] div_cnt_ff;     // Counts prescaler ticks
    reg  [3:0] frac_acc_ff;    // Fractional accumulator
    reg        baud_tick_ff;   // One tick per baud unit
    wire       n_mid     = (n_val != `N_IS_16) & (n_val != `N_IS_1);
    wire       frac_ok   = baud_ff[`BAUD_ADDE] & (frac_ff != `ZERO4) & is_uart7 & n_mid;
    wire [4:0] n_full    = (n_val == `N_IS_16) ? `FRAC_SIXTEEN : {1'b0, n_val};
    wire [4:0] frac_inc  = `FRAC_SIXTEEN - {1'b0, frac_ff};
    wire [4:0] acc_sum   = {1'b0, frac_acc_ff} + frac_inc;
    wire       add_extra = frac_ok & acc_sum[4];
    wire [4:0] div_top   = add_extra ? (n_full + `DIV_ONE) : n_full;

    // Divide prescaler ticks, stretching one unit on fractional carry
    always @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            div_cnt_ff   <= `ZERO5;
            frac_acc_ff  <= `ZERO4;
            baud_tick_ff <= 1'b0;
        end
        else
        begin
            baud_tick_ff <= 1'b0;
            if (presc_tick)
            begin
                if (div_cnt_ff + `DIV_ONE >= div_top)
                begin
                    div_cnt_ff   <= `ZERO5;
                    baud_tick_ff <= 1'b1;
                    // Accumulator steps only when the fraction is legal
                    if (frac_ok)
                        frac_acc_ff <= acc_sum[3:0];
                end
                else
                    div_cnt_ff <= div_cnt_ff + `DIV_ONE;
            end
        end
    end

    // ==========================================================
    // Pin synchronisers: stage 0 feeds only stage 1
    // ==========================================================
    always @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            rxd_sync_ff <= 3'h7;
            sck_sync_ff <= 3'h7;
        end
        else
        begin
            rxd_sync_ff <= {rxd_sync_ff[1:0], receive_data_pin};
            sck_sync_ff <= {sck_sync_ff[1:0], shift_clock_pin_i};
        end
    end

    // ==========================================================
    // Shift engines
    // ==========================================================
    reg [7:0] tx_sh_ff;        // Transmit shifter
    reg [3:0] tx_cnt_ff;       // Transmitted bit count
    reg       tx_busy_ff;      // Transmitter active
    reg [7:0] rx_sh_ff;        // First receive stage
    reg [3:0] rx_cnt_ff;       // Received bit count
    reg       rx_busy_ff;      // Receiver active
    reg       sclk_ff;         // Internal shift clock level
    reg [3:0] os_ff;           // Async transmit sub-bit counter
    reg [3:0] ros_ff;          // Async receive sub-bit counter
    reg [1:0] tx_ph_ff;        // Async tx: 0 start,1 data,2 parity,3 stop
    reg [1:0] rx_ph_ff;        // Async rx phase
    reg       par_ff;          // Running parity

    localparam PH_START  = 2'h0;
    localparam PH_DATA   = 2'h1;
    localparam PH_PARITY = 2'h2;
    localparam PH_STOP   = 2'h3;

    wire pe       = ctrl_ff[`CTRL_PE];
    wire par_even = ctrl_ff[`CTRL_EVEN];
    wire rx_go    = rx_en & ~rx_flag_ff;
    // Internal clock runs while a byte is due in either direction
    wire sync_int_act = is_sync & int_clk & (tx_busy_ff | (rx_go & (full_dpx | ~tx_pend_ff)));
    wire int_fall = sync_int_act & baud_tick_ff & sclk_ff;
    wire int_rise = sync_int_act & baud_tick_ff & ~sclk_ff;
    wire s_fall   = int_clk ? int_fall : (is_sync & sck_fall);
    wire s_rise   = int_clk ? int_rise : (is_sync & sck_rise);
    wire tx_done_sync = tx_busy_ff & is_sync & s_rise & (tx_cnt_ff == `DATA_BITS_SYNC);
    wire rx_done_sync = rx_busy_ff & is_sync & s_rise & (rx_cnt_ff + 4'h1 == `DATA_BITS_SYNC);
    wire tx_done_uart = tx_busy_ff & is_uart7 & baud_tick_ff
                        & (os_ff == `UART_OVERSAMPLE) & (tx_ph_ff == PH_STOP);
    wire rx_done_uart = rx_busy_ff & is_uart7 & baud_tick_ff
                        & (ros_ff == `UART_MID_SAMPLE) & (rx_ph_ff == PH_STOP);
    wire tx_done  = tx_done_sync | tx_done_uart;
    wire rx_done  = rx_done_sync | rx_done_uart;

    // Transmit: sync shifts on falling edge, async sends framed bits
    always @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            tx_sh_ff          <= `ZERO8;
            tx_cnt_ff         <= `BIT_CNT_ZERO;
            tx_busy_ff        <= 1'b0;
            tx_pend_ff        <= 1'b0;
            tx_buf_ff         <= `ZERO8;
            transmit_data_pin <= 1'b1;
            os_ff             <= `ZERO4;
            tx_ph_ff          <= PH_START;
            par_ff            <= 1'b0;
        end
        else
        begin
            if (buf_wr)
            begin
                tx_buf_ff  <= reg_wdata;
                tx_pend_ff <= 1'b1;
            end
            if (!tx_busy_ff && tx_pend_ff && !buf_wr)
            begin
                // Load; sync in either clock mode, async starts frame
                tx_sh_ff   <= tx_buf_ff;
                tx_pend_ff <= 1'b0;
                tx_busy_ff <= 1'b1;
                tx_cnt_ff  <= `BIT_CNT_ZERO;
                os_ff      <= `ZERO4;
                tx_ph_ff   <= PH_START;
                par_ff     <= par_even ? 1'b0 : 1'b1;
                if (is_uart7)
                    transmit_data_pin <= 1'b0;
            end
            else if (tx_busy_ff && is_sync && s_fall && tx_cnt_ff != `DATA_BITS_SYNC)
            begin
                transmit_data_pin <= tx_sh_ff[0];
                tx_sh_ff          <= {1'b0, tx_sh_ff[7:1]};
                tx_cnt_ff         <= tx_cnt_ff + 4'h1;
            end
            else if (tx_done)
            begin
                // Sync: the last bit stays past the final rise so the far side still samples it
                tx_busy_ff        <= 1'b0;
            end
            else if (!tx_busy_ff && baud_tick_ff)
                transmit_data_pin <= 1'b1;                     // Back to idle one tick later
            else if (tx_busy_ff && is_uart7 && baud_tick_ff)
            begin
                os_ff <= os_ff + 4'h1;
                if (os_ff == `UART_OVERSAMPLE)
                begin
                    case (tx_ph_ff)
                        PH_START, PH_DATA:
                        begin
                            if (tx_ph_ff == PH_DATA && tx_cnt_ff == `DATA_BITS_UART7)
                            begin
                                tx_ph_ff          <= pe ? PH_PARITY : PH_STOP;
                                transmit_data_pin <= pe ? par_ff : 1'b1;
                            end
                            else
                            begin
                                tx_ph_ff          <= PH_DATA;
                                transmit_data_pin <= tx_sh_ff[0];
                                par_ff            <= par_ff ^ tx_sh_ff[0];
                                tx_sh_ff          <= {1'b0, tx_sh_ff[7:1]};
                                tx_cnt_ff         <= tx_cnt_ff + 4'h1;
                            end
                        end
                        PH_PARITY:
                        begin
                            tx_ph_ff          <= PH_STOP;
                            transmit_data_pin <= 1'b1;
                        end
                        default:
                            tx_ph_ff <= PH_STOP;
                    endcase
                end
            end
        end
    end

    // Receive: sync samples on rising edge, async mid-bit sampling
    always @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            rx_sh_ff   <= `ZERO8;
            rx_cnt_ff  <= `BIT_CNT_ZERO;
            rx_busy_ff <= 1'b0;
            rx_buf_ff  <= `ZERO8;
            ros_ff     <= `ZERO4;
            rx_ph_ff   <= PH_START;
        end
        else if (!rx_en)
            rx_busy_ff <= 1'b0;
        else if (is_sync)
        begin
            // Half duplex internal clock gives transmit priority
            if (!rx_busy_ff && rx_go && (!int_clk || full_dpx || !tx_busy_ff))
            begin
                rx_busy_ff <= 1'b1;
                rx_cnt_ff  <= `BIT_CNT_ZERO;
            end
            else if (rx_busy_ff && s_rise)
            begin
                rx_sh_ff  <= {rxd_s, rx_sh_ff[7:1]};
                rx_cnt_ff <= rx_cnt_ff + 4'h1;
                if (rx_done_sync)
                begin
                    rx_buf_ff  <= {rxd_s, rx_sh_ff[7:1]};
                    rx_busy_ff <= 1'b0;
                end
            end
        end
        else if (is_uart7)
        begin
            if (!rx_busy_ff && !rxd_s)
            begin
                rx_busy_ff <= 1'b1;
                ros_ff     <= `ZERO4;
                rx_ph_ff   <= PH_START;
                rx_cnt_ff  <= `BIT_CNT_ZERO;
            end
            else if (rx_busy_ff && baud_tick_ff)
            begin
                ros_ff <= ros_ff + 4'h1;
                if (ros_ff == `UART_MID_SAMPLE)
                begin
                    case (rx_ph_ff)
                        PH_START:
                            if (rxd_s)
                                rx_busy_ff <= 1'b0;            // False start
                            else
                                rx_ph_ff <= PH_DATA;
                        PH_DATA:
                        begin
                            rx_sh_ff  <= {1'b0, rxd_s, rx_sh_ff[6:1]};
                            rx_cnt_ff <= rx_cnt_ff + 4'h1;
                            if (rx_cnt_ff + 4'h1 == `DATA_BITS_UART7)
                                rx_ph_ff <= pe ? PH_PARITY : PH_STOP;
                        end
                        PH_PARITY:
                            rx_ph_ff <= PH_STOP;
                        default:
                        begin
                            rx_busy_ff <= 1'b0;
                            rx_buf_ff  <= rx_sh_ff;
                        end
                    endcase
                end
            end
        end
    end

    // ==========================================================
    // Shift clock pin: idles high, driven only with internal clock
    // ==========================================================
    always @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            sclk_ff            <= 1'b1;
            shift_clock_pin_o  <= 1'b1;
            shift_clock_pin_oe <= 1'b0;
        end
        else
        begin
            if (int_fall)
                sclk_ff <= 1'b0;
            else if (int_rise)
                sclk_ff <= 1'b1;
            else if (!sync_int_act)
                sclk_ff <= 1'b1;
            shift_clock_pin_o  <= sclk_ff;
            shift_clock_pin_oe <= is_sync & int_clk;
        end
    end

    // ==========================================================
    // Register writes, flags (set wins over clear), reads
    // ==========================================================
    always @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            mode_a_ff          <= `ZERO8;
            mode_b_ff          <= `ZERO8;
            ctrl_ff            <= `ZERO8;
            baud_ff            <= `ZERO8;
            frac_ff            <= `ZERO4;
            tx_flag_ff         <= 1'b0;
            rx_flag_ff         <= 1'b0;
            reg_rdata          <= `ZERO8;
            transmit_interrupt <= 1'b0;
            receive_interrupt  <= 1'b0;
        end
        else
        begin
            if (reg_wr)
            begin
                case (reg_addr)
                    `ADDR_MODE_A:    mode_a_ff <= reg_wdata;
                    `ADDR_MODE_B:    mode_b_ff <= reg_wdata;
                    `ADDR_CTRL:      ctrl_ff   <= reg_wdata;
                    `ADDR_BAUD_CTRL: baud_ff   <= reg_wdata;
                    `ADDR_FRAC_VAL:  frac_ff   <= reg_wdata[3:0];
                    default:         ;
                endcase
            end
            // Transmit flag clears on buffer write, set wins
            if (tx_done)
                tx_flag_ff <= 1'b1;
            else if (buf_wr)
                tx_flag_ff <= 1'b0;
            // Receive flag clears on buffer read, set wins
            if (rx_done)
                rx_flag_ff <= 1'b1;
            else if (buf_rd)
                rx_flag_ff <= 1'b0;
            transmit_interrupt <= tx_done;
            receive_interrupt  <= rx_done;
            if (reg_rd)
            begin
                case (reg_addr)
                    `ADDR_BUF_CH0:   reg_rdata <= rx_buf_ff;
                    `ADDR_MODE_A:    reg_rdata <= mode_a_ff;
                    `ADDR_MODE_B:    reg_rdata <= mode_b_ff;
                    `ADDR_CTRL:      reg_rdata <= ctrl_ff;
                    `ADDR_BAUD_CTRL: reg_rdata <= baud_ff;
                    `ADDR_FRAC_VAL:  reg_rdata <= {4'h0, frac_ff};
                    `ADDR_IRQ_CTRL:  reg_rdata <= {rx_flag_ff, 3'h0, tx_flag_ff, 3'h0};
                    default:         reg_rdata <= `RD_UNMAPPED;
                endcase
            end
            else
                reg_rdata <= `RD_UNMAPPED;
        end
    end

endmodule

//--- verif/serial_channel_monitor.sv
/* Port checker for serial_channel.
   Assumes it is bound to the design top; shift clock is 32 cycles a half in sync mode. */
`timescale 1ns/1ps
module serial_channel_monitor
(
    input wire       ref_clk,
    input wire       sys_rst,
    input wire       reg_rd,
    input wire [7:0] reg_rdata,
    input wire       transmit_data_pin,
    input wire       shift_clock_pin_o,
    input wire       shift_clock_pin_oe,
    input wire       transmit_interrupt,
    input wire       receive_interrupt
);
    // ==========================================================
    // Burst length counter
    // ==========================================================
    reg [3:0] rise_cnt_ff; // Driven clock rises since last request
    reg       req_q_ff;    // A request was seen last cycle

    // The last rise shows on the pin the cycle after the request; clear then
    always @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            rise_cnt_ff <= 4'h0;
            req_q_ff    <= 1'b0;
        end
        else
        begin
            req_q_ff <= transmit_interrupt || receive_interrupt;
            if (req_q_ff)
                rise_cnt_ff <= 4'h0;
            else if (shift_clock_pin_oe && $rose(shift_clock_pin_o))
                rise_cnt_ff <= rise_cnt_ff + 4'h1;
        end
    end

    // ==========================================================
    // Properties
    // ==========================================================
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    // A shift clock level holds for several cycles
    sequence hold3;
        $stable(shift_clock_pin_o) [*3];
    endsequence

    AST_RD_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data not zero outside read answer");
    AST_TX_PULSE: assert property (transmit_interrupt |=> !transmit_interrupt)
        else $error("transmit request longer than one cycle");
    AST_RX_PULSE: assert property (receive_interrupt |=> !receive_interrupt)
        else $error("receive request longer than one cycle");
    AST_TXD_RISE: assert property (shift_clock_pin_oe && $rose(shift_clock_pin_o) |-> $stable(transmit_data_pin))
        else $error("serial out changed on rising shift clock");
    AST_SCLK_HI: assert property (shift_clock_pin_oe && $rose(shift_clock_pin_o) |=> hold3)
        else $error("shift clock high phase too short");
    AST_SCLK_LO: assert property (shift_clock_pin_oe && $fell(shift_clock_pin_o) |=> hold3)
        else $error("shift clock low phase too short");
    AST_BURST_EIGHT: assert property (req_q_ff && shift_clock_pin_oe |-> rise_cnt_ff == 4'h7 && $rose(shift_clock_pin_o))
        else $error("burst did not hold eight clocks");
    AST_BURST_MAX: assert property (shift_clock_pin_oe |-> rise_cnt_ff <= 4'h7)
        else $error("burst longer than eight clocks");
endmodule

bind serial_channel serial_channel_monitor serial_channel_monitor_inst (.ref_clk, .sys_rst, .reg_rd, .reg_rdata,
    .transmit_data_pin, .shift_clock_pin_o, .shift_clock_pin_oe, .transmit_interrupt, .receive_interrupt);

//--- verif/shift_partner.sv
/* Far side model: external shift register and shift clock source.
   Assumes the bench resolves the shift clock wire from both drivers. */
`timescale 1ns/1ps
module shift_partner
(
    input  wire       ref_clk,
    input  wire       sclk_wire,  // Resolved shift clock
    input  wire       txd,        // Device serial out
    input  wire       load,       // Load reply byte
    input  wire [7:0] reply,      // Byte sent to the device
    input  wire       run,        // Start one external burst
    output reg  [7:0] cap_ff,     // Bytes seen, LSB first
    output reg        rxd_ff,     // Device serial in
    output reg        ext_clk_ff  // External clock, idles high
);
    reg [8:0] ecnt_ff;   // External burst phase
    reg [7:0] rep_ff;    // Reply byte
    reg [3:0] idx_ff;    // Next reply bit
    reg       sclk_q_ff; // Clock last cycle

    initial
    begin
        {ecnt_ff, rep_ff, cap_ff} = 25'h0;
        idx_ff = 4'h8;
        {rxd_ff, ext_clk_ff, sclk_q_ff} = 3'h7;
    end

    // Sample on rise, drive on fall, LSB first
    always @(posedge ref_clk)
    begin
        sclk_q_ff <= sclk_wire;
        if (sclk_wire && !sclk_q_ff)
            cap_ff <= {txd, cap_ff[7:1]};
        if (load)
        begin
            rep_ff <= reply;
            idx_ff <= 4'h0;
        end
        else if (!sclk_wire && sclk_q_ff)
        begin
            rxd_ff <= (idx_ff < 4'h8) ? rep_ff[idx_ff[2:0]] : ~rxd_ff;
            idx_ff <= (idx_ff < 4'h8) ? idx_ff + 4'h1 : idx_ff;
        end
        // Eight periods of 32 cycles, then stand still high
        if (run)
            ecnt_ff <= 9'h001;
        else if (ecnt_ff != 9'h000)
            ecnt_ff <= (ecnt_ff == 9'h100) ? 9'h000 : ecnt_ff + 9'h001;
        ext_clk_ff <= (ecnt_ff == 9'h000) | ~ecnt_ff[4];
    end
endmodule

//--- verif/testbench.sv
/* Self-checking bench for serial_channel.
   Assumes design, checker and partner model are compiled first. */
`timescale 1ns/1ps
module testbench;
    reg        ref_clk = 1'b0;
    reg        sys_rst = 1'b1;
    reg        presc_tick = 1'b0;
    reg [11:0] reg_addr = 12'h000;
    reg [7:0]  reg_wdata = 8'h00;
    reg        reg_wr = 1'b0;
    reg        reg_rd = 1'b0;
    reg        load = 1'b0;
    reg        run = 1'b0;
    reg        hit;
    reg [7:0]  reply = 8'h00;
    reg [7:0]  rdv;
    reg [9:0]  frame;
    wire [7:0] reg_rdata, cap;
    wire       transmit_data_pin, receive_data_pin, shift_clock_pin_o, shift_clock_pin_oe;
    wire       shift_clock_pin_i, transmit_interrupt, receive_interrupt;
    wire       sclk_wire = shift_clock_pin_oe ? shift_clock_pin_o : shift_clock_pin_i;
    integer    mismatches = 0;
    integer    n_compared = 0;
    integer    i, k;

    serial_channel serial_channel_inst (.ref_clk, .sys_rst, .presc_tick, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata, .transmit_data_pin, .receive_data_pin, .shift_clock_pin_o,
        .shift_clock_pin_oe, .shift_clock_pin_i, .transmit_interrupt, .receive_interrupt);
    shift_partner shift_partner_inst (.ref_clk, .sclk_wire, .txd(transmit_data_pin), .load, .reply, .run,
        .cap_ff(cap), .rxd_ff(receive_data_pin), .ext_clk_ff(shift_clock_pin_i));

    // Clock and a prescaler tick every other cycle
    initial forever #4 ref_clk = ~ref_clk;
    always @(posedge ref_clk) presc_tick <= ~presc_tick;

    task wr(input [11:0] a, input [7:0] d);
    begin
        @(posedge ref_clk);
        {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    end
    endtask

    task rd(input [11:0] a, output [7:0] d);
    begin
        @(posedge ref_clk);
        {reg_rd, reg_addr} <= {1'b1, a};
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    end
    endtask

    task chk(input [71:0] nm, input [7:0] e, input [7:0] g);
    begin
        n_compared = n_compared + 1;
        if (g !== e)
        begin
            mismatches = mismatches + 1;
            $display("BAD %0s exp %h got %h", nm, e, g);
        end
    end
    endtask

    // Bounded wait for one request pulse
    task wait_irq(input sel, input integer lim);
        integer w;
    begin
        hit = 1'b0;
        for (w = 0; w < lim && !hit; w = w + 1)
        begin
            @(posedge ref_clk);
            #1 hit = sel ? (receive_interrupt === 1'b1) : (transmit_interrupt === 1'b1);
        end
    end
    endtask

    task print_verdict;
    begin
        if (mismatches == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    end
    endtask

    initial
    begin
        #200000 mismatches = mismatches + 1;
        print_verdict;
    end

    initial
    begin
        repeat (12) @(posedge ref_clk);
        sys_rst <= 1'b0;
        rd(12'h3FF, rdv); chk("unmapped", 8'h00, rdv);
        rd(12'h206, rdv); chk("flags", 8'h00, rdv);
        wr(12'h200, 8'h5A);
        wait_irq(1'b0, 2000); chk("tx irq", 8'h01, {7'h0, hit});
        repeat (3) @(posedge ref_clk);
        chk("sync tx", 8'h5A, cap);
        rd(12'h206, rdv); chk("tx flag", 8'h08, rdv & 8'h08);
        reply <= 8'h3C;
        load <= 1'b1;
        @(posedge ref_clk);
        load <= 1'b0;
        wait_irq(1'b1, 600); chk("rx off", 8'h00, {7'h0, hit});
        wr(12'h201, 8'h20);
        wait_irq(1'b1, 2000); chk("rx irq", 8'h01, {7'h0, hit});
        wr(12'h201, 8'h00);
        rd(12'h200, rdv); chk("sync rx", 8'h3C, rdv);
        wr(12'h202, 8'h01);
        wr(12'h200, 8'hC3);
        run <= 1'b1;
        @(posedge ref_clk);
        run <= 1'b0;
        wait_irq(1'b0, 2000); chk("ext tx", 8'hC3, cap);
        wr(12'h203, 8'h02);
        wr(12'h201, 8'h01);
        for (i = 0; i < 3; i = i + 1)
        begin
            frame = {1'b1, (i == 0) ? ^7'h15 : (i == 1) ? ~^7'h15 : 1'b1, 7'h15, 1'b0};
            wr(12'h202, (i == 0) ? 8'h60 : (i == 1) ? 8'h20 : 8'h00);
            wr(12'h200, 8'h15);
            for (k = 0; k < 400 && transmit_data_pin !== 1'b0; k = k + 1)
                @(posedge ref_clk);
            repeat (32) @(posedge ref_clk);
            for (k = 0; k < 10; k = k + 1)
            begin
                chk("uart bit", {7'h0, frame[k]}, {7'h0, transmit_data_pin});
                repeat (64) @(posedge ref_clk);
            end
        end
        print_verdict;
    end
endmodule
